// >>> rtl/fta_pkg.sv
package fta_pkg;

    // pointer geometry
    localparam int PTR_W = 22;
    localparam int ARRAY_ADDR_W = 21;
    localparam int SPACE_BIT = 21;
    localparam int UPPER_W = 6;
    localparam int HOLD_SEL_W = 3;
    localparam int HOLD_COUNT = 8;
    localparam int BLOCK_LSB = 3;
    localparam int ROW_LSB = 6;
    localparam int HOLD_DATA_W = 64;

    // table pointer update modes
    localparam logic [1:0] MODE_KEEP = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC = 2'h3;

    // memory control register bit positions
    localparam int CTRL_PROG_SPACE = 7;
    localparam int CTRL_CFG_SPACE = 6;
    localparam int CTRL_ROW_ERASE = 4;
    localparam int CTRL_WR_ABORT = 3;
    localparam int CTRL_WR_ENABLE = 2;
    localparam int CTRL_WR_START = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // unlock key bytes
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

    // timed operation length
    localparam int CLK_MHZ = 25;
    localparam int LONG_WRITE_US = 2000;
    localparam int LONG_WRITE_CYCLES = LONG_WRITE_US * CLK_MHZ;
    localparam int TIMER_W = 16;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_KEY1 = 2'b01,
        ST_ARMED = 2'b10,
        ST_BUSY = 2'b11
    } fta_state_t;

endpackage

// >>> rtl/fta_flash_table_access.sv
`timescale 1ns/1ns
`default_nettype none

module fta_flash_table_access #(
    parameter int LONG_WRITE_CYCLES = fta_pkg::LONG_WRITE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] wr_data,
    input wire logic ptr_upper_wr,
    input wire logic ptr_high_wr,
    input wire logic ptr_low_wr,
    input wire logic latch_wr,
    input wire logic table_read_op,
    input wire logic table_write_op,
    input wire logic [1:0] table_mode,
    input wire logic ctrl_wr,
    input wire logic unlock_wr,
    input wire logic irq_flag_clr,
    input wire logic abort_req,
    input wire logic [15:0] flash_rdata,
    output logic [21:0] table_pointer_ff,
    output logic [7:0] table_latch_ff,
    output logic [7:0] memory_control_reg_ff,
    output logic write_done_irq_flag_ff,
    output logic core_stall_ff,
    output logic [21:0] flash_addr_ff,
    output logic flash_rd_ff,
    output logic flash_erase_ff,
    output logic flash_prog_ff,
    output logic flash_abort_ff,
    output logic [63:0] hold_data_ff
);

    // one automatic step on the array part of the pointer
    function automatic logic [21:0] fta_ptr_step(input logic [21:0] p, input logic up);
        logic [20:0] low;
        low = up ? (p[20:0] + 21'h000001) : (p[20:0] - 21'h000001);
        return {p[fta_pkg::SPACE_BIT], low};
    endfunction

    // clear the low address bits below an operation's boundary
    function automatic logic [21:0] fta_align(input logic [21:0] p, input int lsb);
        logic [21:0] mask;
        mask = ~((22'h000001 << lsb) - 22'h000001);
        return p & mask;
    endfunction

    localparam logic [15:0] TIMER_LAST = 16'(LONG_WRITE_CYCLES - 1);

    fta_pkg::fta_state_t st_ff;
    fta_pkg::fta_state_t nxt_st;
    logic [15:0] timer_ff;
    logic [15:0] nxt_timer;
    logic rd_pend_ff;
    logic op_erase_ff;

    // control bits in view
    wire busy = (st_ff == fta_pkg::ST_BUSY);
    wire prog_space = memory_control_reg_ff[fta_pkg::CTRL_PROG_SPACE];
    wire cfg_space = memory_control_reg_ff[fta_pkg::CTRL_CFG_SPACE];
    wire row_erase = memory_control_reg_ff[fta_pkg::CTRL_ROW_ERASE];
    wire wr_abort = memory_control_reg_ff[fta_pkg::CTRL_WR_ABORT];
    wire wr_enable = memory_control_reg_ff[fta_pkg::CTRL_WR_ENABLE];
    wire wr_start = memory_control_reg_ff[fta_pkg::CTRL_WR_START];

    // core strobes, ignored while the core is stalled
    wire tbl_rd = table_read_op & ~busy;
    wire tbl_wt = table_write_op & ~busy;
    wire tbl_op = tbl_rd | tbl_wt;
    wire ctrl_take = ctrl_wr & ~busy;
    wire unlock_take = unlock_wr & ~busy;
    wire other_access = ptr_upper_wr | ptr_high_wr | ptr_low_wr | latch_wr | tbl_op;

    // pointer arithmetic for table operations
    wire [21:0] ptr_inc = fta_ptr_step(table_pointer_ff, 1'b1);
    wire [21:0] ptr_dec = fta_ptr_step(table_pointer_ff, 1'b0);
    wire pre_inc = (table_mode == fta_pkg::MODE_PRE_INC);
    wire [21:0] acc_addr = pre_inc ? ptr_inc : table_pointer_ff;
    wire [21:0] ptr_after =
        (table_mode == fta_pkg::MODE_KEEP) ? table_pointer_ff :
        (table_mode == fta_pkg::MODE_POST_DEC) ? ptr_dec : ptr_inc;

    // direct byte writes into the three pointer bytes
    wire [21:0] ptr_u = {wr_data[fta_pkg::UPPER_W-1:0], table_pointer_ff[15:0]};
    wire [21:0] ptr_h = {table_pointer_ff[21:16], wr_data, table_pointer_ff[7:0]};
    wire [21:0] ptr_l = {table_pointer_ff[21:8], wr_data};
    wire [21:0] nxt_ptr =
        busy ? table_pointer_ff :
        tbl_op ? ptr_after :
        ptr_upper_wr ? ptr_u :
        ptr_high_wr ? ptr_h :
        ptr_low_wr ? ptr_l : table_pointer_ff;

    // unlock qualification and start decision
    wire key1_hit = unlock_take & (wr_data == fta_pkg::UNLOCK_KEY1);
    wire key2_hit = unlock_take & (wr_data == fta_pkg::UNLOCK_KEY2);
    wire start_req = ctrl_take & wr_data[fta_pkg::CTRL_WR_START];
    wire start_ok = wr_data[fta_pkg::CTRL_WR_ENABLE] & wr_data[fta_pkg::CTRL_PROG_SPACE];
    wire start = (st_ff == fta_pkg::ST_ARMED) & start_req & start_ok;
    wire start_erase = wr_data[fta_pkg::CTRL_ROW_ERASE];
    wire start_cfg = wr_data[fta_pkg::CTRL_CFG_SPACE];

    // timer end and reset abort of a running operation
    wire done = busy & (timer_ff == 16'h0000) & ~abort_req;
    wire abort_hit = busy & abort_req;

    // target address of the timed operation, aligned to its unit
    wire [21:0] op_base = {table_pointer_ff[fta_pkg::SPACE_BIT] | start_cfg,
        table_pointer_ff[20:0]};
    wire [21:0] op_addr = start_erase ? fta_align(op_base, fta_pkg::ROW_LSB) :
        fta_align(op_base, fta_pkg::BLOCK_LSB);

    // unlock sequencer and timed operation
    always_comb begin
        nxt_st = st_ff;
        nxt_timer = timer_ff;
        case (st_ff)
            fta_pkg::ST_IDLE: begin
                if (key1_hit) begin
                    nxt_st = fta_pkg::ST_KEY1;
                end
            end
            fta_pkg::ST_KEY1: begin
                if (key2_hit) begin
                    nxt_st = fta_pkg::ST_ARMED;
                end else if (key1_hit) begin
                    nxt_st = fta_pkg::ST_KEY1;
                end else if (unlock_take | ctrl_take | other_access) begin
                    nxt_st = fta_pkg::ST_IDLE;
                end
            end
            fta_pkg::ST_ARMED: begin
                if (start) begin
                    nxt_st = fta_pkg::ST_BUSY;
                    nxt_timer = TIMER_LAST;
                end else if (key1_hit) begin
                    nxt_st = fta_pkg::ST_KEY1;
                end else if (unlock_take | ctrl_take | other_access) begin
                    nxt_st = fta_pkg::ST_IDLE;
                end
            end
            fta_pkg::ST_BUSY: begin
                if (done | abort_hit) begin
                    nxt_st = fta_pkg::ST_IDLE;
                end else begin
                    nxt_timer = timer_ff - 16'h0001;
                end
            end
            default: begin
                nxt_st = fta_pkg::ST_IDLE;
            end
        endcase
        if (abort_req & ~busy) begin
            nxt_st = fta_pkg::ST_IDLE;
        end
    end

    // control register next value, bit by bit
    wire nxt_prog_space = ctrl_take ? wr_data[fta_pkg::CTRL_PROG_SPACE] : prog_space;
    wire nxt_cfg_space = ctrl_take ? wr_data[fta_pkg::CTRL_CFG_SPACE] : cfg_space;
    wire nxt_row_erase = (done & op_erase_ff) ? 1'b0 :
        ctrl_take ? wr_data[fta_pkg::CTRL_ROW_ERASE] : row_erase;
    wire nxt_wr_abort = abort_hit ? 1'b1 :
        ctrl_take ? wr_data[fta_pkg::CTRL_WR_ABORT] : wr_abort;
    wire nxt_wr_enable = ctrl_take ? wr_data[fta_pkg::CTRL_WR_ENABLE] : wr_enable;
    wire nxt_wr_start = start ? 1'b1 : (done | abort_hit) ? 1'b0 : wr_start;
    wire [7:0] nxt_ctrl = {nxt_prog_space, nxt_cfg_space, 1'b0, nxt_row_erase,
        nxt_wr_abort, nxt_wr_enable, nxt_wr_start, 1'b0};

    // completion flag, a new completion wins over a clear
    wire nxt_irq_flag = done ? 1'b1 : irq_flag_clr ? 1'b0 : write_done_irq_flag_ff;

    // byte picked from the returned word
    wire [7:0] rd_byte = flash_addr_ff[0] ? flash_rdata[15:8] : flash_rdata[7:0];
    wire [7:0] nxt_latch = rd_pend_ff ? rd_byte :
        (latch_wr & ~busy) ? wr_data : table_latch_ff;

    // holding register slot written by a table write
    wire [5:0] hold_lsb = {acc_addr[fta_pkg::HOLD_SEL_W-1:0], 3'b000};
    wire [21:0] nxt_flash_addr = tbl_rd ? acc_addr :
        start ? op_addr : flash_addr_ff;

    // stall and operation kind, held for the whole timed operation
    wire nxt_stall = start | (busy & ~done & ~abort_hit);
    wire nxt_op_erase = start ? start_erase : op_erase_ff;

    // sequencer state and timer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= fta_pkg::ST_IDLE;
            timer_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            timer_ff <= nxt_timer;
        end
    end

    // table pointer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            table_pointer_ff <= 22'h000000;
        end else begin
            table_pointer_ff <= nxt_ptr;
        end
    end

    // control register and completion flag
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            memory_control_reg_ff <= fta_pkg::CTRL_RESET;
            write_done_irq_flag_ff <= 1'b0;
        end else begin
            memory_control_reg_ff <= nxt_ctrl;
            write_done_irq_flag_ff <= nxt_irq_flag;
        end
    end

    // core stall and kind of the running operation
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            core_stall_ff <= 1'b0;
            op_erase_ff <= 1'b0;
        end else begin
            core_stall_ff <= nxt_stall;
            op_erase_ff <= nxt_op_erase;
        end
    end

    // table latch and pending read
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            table_latch_ff <= 8'h00;
            rd_pend_ff <= 1'b0;
        end else begin
            table_latch_ff <= nxt_latch;
            rd_pend_ff <= tbl_rd;
        end
    end

    // array read strobe and address
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flash_rd_ff <= 1'b0;
            flash_addr_ff <= 22'h000000;
        end else begin
            flash_rd_ff <= tbl_rd;
            flash_addr_ff <= nxt_flash_addr;
        end
    end

    // holding registers, touched only by table writes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hold_data_ff <= 64'h0000000000000000;
        end else if (tbl_wt) begin
            hold_data_ff[hold_lsb +: 8] <= table_latch_ff;
        end
    end

    // array erase and program pulses
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flash_erase_ff <= 1'b0;
            flash_prog_ff <= 1'b0;
        end else begin
            flash_erase_ff <= start & start_erase;
            flash_prog_ff <= start & ~start_erase;
        end
    end

    // array abort pulse
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flash_abort_ff <= 1'b0;
        end else begin
            flash_abort_ff <= abort_hit;
        end
    end

endmodule // fta_flash_table_access

`default_nettype wire

// >>> tb/fta_sva.sv
`timescale 1ns/1ns
`default_nettype none

module fta_sva #(
    parameter int LONG_WRITE_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] wr_data,
    input wire logic table_read_op,
    input wire logic table_write_op,
    input wire logic ctrl_wr,
    input wire logic irq_flag_clr,
    input wire logic abort_req,
    input wire logic [15:0] flash_rdata,
    input wire logic [21:0] table_pointer_ff,
    input wire logic [7:0] table_latch_ff,
    input wire logic [7:0] memory_control_reg_ff,
    input wire logic write_done_irq_flag_ff,
    input wire logic core_stall_ff,
    input wire logic [21:0] flash_addr_ff,
    input wire logic flash_rd_ff,
    input wire logic flash_erase_ff,
    input wire logic flash_prog_ff,
    input wire logic flash_abort_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // counts cycles of the current stall
    logic [15:0] stall_cnt_ff;
    logic [15:0] nxt_stall_cnt;
    assign nxt_stall_cnt = core_stall_ff ? stall_cnt_ff + 16'h1 : 16'h0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) stall_cnt_ff <= 16'h0;
        else stall_cnt_ff <= nxt_stall_cnt;
    end

    // timed operations, start to finish
    chk_stall_len: assert property (
        $fell(core_stall_ff) && !memory_control_reg_ff[3] |-> stall_cnt_ff == LONG_WRITE_CYCLES)
        else $error("stall length wrong");
    chk_done_bits: assert property (
        $fell(core_stall_ff) && !memory_control_reg_ff[3] |-> write_done_irq_flag_ff
        && !memory_control_reg_ff[1] && !memory_control_reg_ff[4])
        else $error("completion bits wrong");
    chk_flag_sticky: assert property (
        write_done_irq_flag_ff && !irq_flag_clr |=> write_done_irq_flag_ff)
        else $error("done flag dropped");
    chk_start_pulse: assert property (
        $rose(core_stall_ff) |-> (flash_erase_ff || flash_prog_ff) && memory_control_reg_ff[1])
        else $error("start without pulse");
    chk_start_cause: assert property (
        $rose(core_stall_ff) |-> $past(ctrl_wr) && (($past(wr_data) & 8'h86) == 8'h86))
        else $error("start without enabled write");
    chk_erase_align: assert property (
        flash_erase_ff |-> flash_addr_ff[5:0] == 6'h0 && core_stall_ff)
        else $error("erase address not row aligned");
    chk_prog_align: assert property (
        flash_prog_ff |-> flash_addr_ff[2:0] == 3'h0 && core_stall_ff)
        else $error("program address not block aligned");
    chk_abort_end: assert property (
        abort_req && core_stall_ff |=> !core_stall_ff && flash_abort_ff
        && memory_control_reg_ff[3] && memory_control_reg_ff[7:6] == $past(memory_control_reg_ff[7:6]))
        else $error("abort handling wrong");
    chk_top_bit_kept: assert property (
        (table_read_op || table_write_op) && !core_stall_ff |=> $stable(table_pointer_ff[21]))
        else $error("pointer top bit changed");
    chk_read_byte: assert property (
        flash_rd_ff |=> table_latch_ff == ($past(flash_addr_ff[0]) ?
        $past(flash_rdata[15:8]) : $past(flash_rdata[7:0])))
        else $error("latch byte wrong");
endmodule // fta_sva

bind fta_flash_table_access fta_sva #(.LONG_WRITE_CYCLES(LONG_WRITE_CYCLES)) fta_sva_inst (.*);

`default_nettype wire

// >>> tb/fta_flash_model.sv
`timescale 1ns/1ns
`default_nettype none

module fta_flash_model (
    input wire logic [21:0] addr,
    input wire logic rd,
    output logic [15:0] rdata
);
    logic [15:0] word;
    // one 16-bit word per even byte address
    assign word = {addr[8:1] ^ 8'h3c, addr[8:1]};
    // outside a read the bus shows a changed word, never a stale copy
    assign rdata = rd ? word : ~word;
endmodule // fta_flash_model

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
    localparam int NCYC = 8;
    logic clk_sys, rst_b, abort_req;
    logic [7:0] wr_data, table_latch_ff, memory_control_reg_ff;
    logic [1:0] table_mode;
    logic [8:0] strb;
    logic ptr_upper_wr, ptr_high_wr, ptr_low_wr, latch_wr, table_read_op, table_write_op;
    logic ctrl_wr, unlock_wr, irq_flag_clr, write_done_irq_flag_ff, core_stall_ff;
    logic flash_rd_ff, flash_erase_ff, flash_prog_ff, flash_abort_ff;
    logic [15:0] flash_rdata;
    logic [21:0] table_pointer_ff, flash_addr_ff;
    logic [63:0] hold_data_ff;
    int n_fail = 0;
    int samples_checked = 0;

    // strobes 0 upper, 1 high, 2 low, 3 latch, 4 read, 5 write, 6 ctrl, 7 unlock, 8 clear
    assign {irq_flag_clr, unlock_wr, ctrl_wr, table_write_op, table_read_op, latch_wr,
        ptr_low_wr, ptr_high_wr, ptr_upper_wr} = strb;

    fta_flash_table_access #(.LONG_WRITE_CYCLES(NCYC)) fta_flash_table_access_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .wr_data(wr_data), .ptr_upper_wr(ptr_upper_wr),
        .ptr_high_wr(ptr_high_wr), .ptr_low_wr(ptr_low_wr), .latch_wr(latch_wr),
        .table_read_op(table_read_op), .table_write_op(table_write_op),
        .table_mode(table_mode), .ctrl_wr(ctrl_wr), .unlock_wr(unlock_wr),
        .irq_flag_clr(irq_flag_clr), .abort_req(abort_req), .flash_rdata(flash_rdata),
        .table_pointer_ff(table_pointer_ff), .table_latch_ff(table_latch_ff),
        .memory_control_reg_ff(memory_control_reg_ff), .core_stall_ff(core_stall_ff),
        .write_done_irq_flag_ff(write_done_irq_flag_ff), .flash_addr_ff(flash_addr_ff),
        .flash_rd_ff(flash_rd_ff), .flash_erase_ff(flash_erase_ff),
        .flash_prog_ff(flash_prog_ff), .flash_abort_ff(flash_abort_ff),
        .hold_data_ff(hold_data_ff));
    fta_flash_model fta_flash_model_inst (.addr(flash_addr_ff), .rd(flash_rd_ff),
        .rdata(flash_rdata));

    // 25 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one-cycle core strobe, driven on the falling edge
    task automatic core(input int k, input logic [7:0] d, input logic [1:0] m = 2'h0);
        @(negedge clk_sys);
        strb = 9'h1 << k;
        wr_data = d;
        table_mode = m;
        @(negedge clk_sys);
        strb = 9'h0;
    endtask

    task automatic set_ptr(input logic [21:0] p);
        core(0, {2'h0, p[21:16]});
        core(1, p[15:8]);
        core(2, p[7:0]);
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_modes;
        logic [21:0] e, a;
        logic [1:0] m;
        e = 22'h3fffff;
        set_ptr(e);
        check("ptr", e, table_pointer_ff);
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            a = (m == fta_pkg::MODE_PRE_INC) ? {e[21], e[20:0] + 21'h1} : e;
            if (m == fta_pkg::MODE_POST_DEC) e = {e[21], e[20:0] - 21'h1};
            else if (m != fta_pkg::MODE_KEEP) e = {e[21], e[20:0] + 21'h1};
            core(4, 8'h00, m);
            check("addr", a, flash_addr_ff);
            check("ptr", e, table_pointer_ff);
            check("rd", 1'b1, flash_rd_ff);
            @(negedge clk_sys);
            check("rd", 1'b0, flash_rd_ff);
            check("latch", a[0] ? a[8:1] ^ 8'h3c : a[8:1], table_latch_ff);
        end
    endtask

    task automatic t_hold;
        logic [63:0] h;
        h = 64'h0;
        set_ptr(22'h000005);
        for (int i = 0; i < 8; i++) begin
            core(3, 8'h10 + i[7:0]);
            core(5, 8'h00, fta_pkg::MODE_POST_INC);
            h[8 * ((5 + i) % 8) +: 8] = 8'h10 + i[7:0];
        end
        check("hold", h, hold_data_ff);
        check("stall", 1'b0, core_stall_ff);
    endtask

    // unlock, start, then time the stall and the completion
    task automatic start_op(input logic [7:0] c, input logic [21:0] a, input logic er);
        int n;
        n = 0;
        core(7, fta_pkg::UNLOCK_KEY1);
        core(7, fta_pkg::UNLOCK_KEY2);
        core(6, c);
        check("pulse", {er, ~er}, {flash_erase_ff, flash_prog_ff});
        check("opaddr", a, flash_addr_ff);
        while (core_stall_ff === 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        check("stall len", NCYC, n);
        @(negedge clk_sys);
        check("ctrl", c & 8'hed, memory_control_reg_ff);
        check("flag", 1'b1, write_done_irq_flag_ff);
        core(8, 8'h00);
        check("flag", 1'b0, write_done_irq_flag_ff);
    endtask

    task automatic t_erase;
        core(7, fta_pkg::UNLOCK_KEY1);
        core(3, 8'h00);
        core(7, fta_pkg::UNLOCK_KEY2);
        core(6, 8'h96);
        check("start", 1'b0, core_stall_ff);
        check("ctrl", 8'h94, memory_control_reg_ff);
        core(7, fta_pkg::UNLOCK_KEY1);
        core(7, fta_pkg::UNLOCK_KEY2);
        core(6, 8'h92);
        check("start", 1'b0, core_stall_ff);
        set_ptr(22'h00127f);
        start_op(8'h96, 22'h001240, 1'b1);
    endtask

    task automatic t_abort;
        core(7, fta_pkg::UNLOCK_KEY1);
        core(7, fta_pkg::UNLOCK_KEY2);
        core(6, 8'hc6);
        check("opaddr", 22'h201278, flash_addr_ff);
        core(2, 8'h77);
        check("ptr", 22'h00127f, table_pointer_ff);
        abort_req = 1'b1;
        @(negedge clk_sys);
        abort_req = 1'b0;
        check("stall", 1'b0, core_stall_ff);
        check("ctrl", 8'hcc, memory_control_reg_ff);
        check("abort", 1'b1, flash_abort_ff);
        check("flag", 1'b0, write_done_irq_flag_ff);
        core(7, fta_pkg::UNLOCK_KEY1);
        core(7, fta_pkg::UNLOCK_KEY2);
        abort_req = 1'b1;
        @(negedge clk_sys);
        abort_req = 1'b0;
        core(6, 8'h86);
        check("start", 1'b0, core_stall_ff);
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        abort_req = 1'b0;
        strb = 9'h0;
        wr_data = 8'h00;
        table_mode = 2'h0;
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        check("ctrl", fta_pkg::CTRL_RESET, memory_control_reg_ff);
        check("ptr", 22'h0, table_pointer_ff);
        t_modes;
        t_hold;
        start_op(8'h86, 22'h000008, 1'b0);
        t_erase;
        t_abort;
        end_sim;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        end_sim;
    end
endmodule // testbench

`default_nettype wire
